/* src/cms_regs.vh */
/*
 * Constants of the command-mode and sleep control block: command codes,
 * reset values, legal ranges and timing counts.
 * Assumes a 250 MHz reference clock; included by the design files only.
 */
`ifndef CMS_REGS_VH
`define CMS_REGS_VH

// parameter selectors on the command port
`define CMS_CMD_FIRMWARE_REV    4'h0
`define CMS_CMD_HARDWARE_REV    4'h1
`define CMS_CMD_SUPPLY_VOLTAGE  4'h2
`define CMS_CMD_CMD_TIMEOUT     4'h3
`define CMS_CMD_GUARD_TIME      4'h4
`define CMS_CMD_ESCAPE_CHAR     4'h5
`define CMS_CMD_SLEEP_MODE      4'h6
`define CMS_CMD_SILENT_WAKE     4'h7
`define CMS_CMD_SLEEP_INTERVAL  4'h8
`define CMS_CMD_IDLE_BEFORE     4'h9
`define CMS_CMD_LEAVE_CMD_MODE  4'hf

// reset values
`define CMS_RST_CMD_TIMEOUT     16'h0064
`define CMS_RST_GUARD_TIME      16'h03e8
`define CMS_RST_ESCAPE_CHAR     8'h2b
`define CMS_RST_SLEEP_MODE      8'h00
`define CMS_RST_SILENT_WAKE     16'h0001
`define CMS_RST_SLEEP_INTERVAL  16'h0020
`define CMS_RST_IDLE_BEFORE     16'h1388

// legal ranges
`define CMS_MIN_CMD_TIMEOUT     16'h0002
`define CMS_MAX_CMD_TIMEOUT     16'h028f
`define CMS_MIN_GUARD_TIME      16'h0001
`define CMS_MAX_GUARD_TIME      16'h0ce4
`define CMS_MIN_SILENT_WAKE     16'h0001
`define CMS_MIN_SLEEP_INTERVAL  16'h0020
`define CMS_MAX_SLEEP_INTERVAL  16'h0af0
`define CMS_MIN_IDLE_BEFORE     16'h0001
`define CMS_MAX_IDLE_BEFORE     16'hfffe

// sleep modes
`define CMS_SLEEP_OFF           8'h00
`define CMS_SLEEP_PIN           8'h01
`define CMS_SLEEP_CYCLIC        8'h04

// escape sequence length
`define CMS_ESCAPE_COUNT        2'h3

// timing: units and derived cycle counts
`define CMS_CLK_PERIOD_NS       4
`define CMS_MS_NS               1000000
`define CMS_MS_CYCLES           (`CMS_MS_NS / `CMS_CLK_PERIOD_NS)
`define CMS_CMD_UNIT_MS         17'd100
`define CMS_SLEEP_UNIT_MS       16'd10
`define CMS_QUARTER_UNITS       16'd25
`define CMS_MAX_SLEEP_UNITS     16'd2800

// supply scaling: millivolts = raw * 1200 / 1023
`define CMS_SUPPLY_MUL          28'd1200
`define CMS_SUPPLY_DIV          28'd1023

`endif

/* src/cms_ms_tick.v */
/*
 * Millisecond tick generator: one-cycle pulse every DIV clock cycles.
 * Assumes a free-running clock and a synchronous active-low reset.
 */
`default_nettype none

module cms_ms_tick #(
	parameter DIV = 250000
) (
	input  wire ref_clk,
	input  wire reset_n,
	output reg  tick
);

	reg [31:0] count;

	// divider restarts from zero at reset so the first tick is a full ms away
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			count <= 32'h0000_0000;
			tick  <= 1'b0;
		end else if (count == DIV - 1) begin
			count <= 32'h0000_0000;
			tick  <= 1'b1;
		end else begin
			count <= count + 32'h0000_0001;
			tick  <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* src/cms_control.v */
/*
 * Command-mode entry/exit and sleep control of a serial-attached radio node.
 * Assumes serial bytes and command requests arrive as one-cycle strobes
 * synchronous to ref_clk, already decoded by a receiver outside this block.
 */
`include "cms_regs.vh"
`default_nettype none

module cms_control #(
	parameter        MS_CYCLES    = `CMS_MS_CYCLES,
	parameter [15:0] FIRMWARE_REV = 16'h1234, // arbitrary value
	parameter [15:0] HARDWARE_REV = 16'h0abc  // arbitrary value
) (
	input  wire        ref_clk,
	input  wire        reset_n,
	input  wire        rxValid,
	input  wire [7:0]  rxByte,
	input  wire        radioRx,
	input  wire        radioPending,
	input  wire        sleepPinRequest,
	input  wire [15:0] supplyRaw,
	input  wire        cmdValid,
	input  wire        cmdWrite,
	input  wire [3:0]  cmdCode,
	input  wire [15:0] cmdData,
	output reg         rspValid,
	output reg         rspError,
	output reg  [15:0] rspData,
	output reg         commandMode,
	output reg         routerRole,
	output reg         rejoinPulse,
	output reg         sleeping,
	output reg         awakeIndicator,
	output reg  [15:0] bufferHoldUnits
);

	localparam [1:0] MODE_IDLE  = 2'b01;
	localparam [1:0] MODE_CMD   = 2'b10;
	localparam [1:0] SLP_AWAKE  = 2'b01;
	localparam [1:0] SLP_ASLEEP = 2'b10;

	// programmable parameters
	reg [15:0] command_mode_timeout;
	reg [15:0] guard_time;
	reg [7:0]  escape_character;
	reg [7:0]  sleep_mode_select;
	reg [15:0] silent_wake_count;
	reg [15:0] sleep_interval;
	reg [15:0] idle_before_sleep;

	reg [1:0]  modeState;
	reg [1:0]  sleepState;
	reg [15:0] silentMs;
	reg [1:0]  escCount;
	reg [16:0] cmdIdleMs;
	reg [15:0] idleMs;
	reg [15:0] sleepMs;
	reg [15:0] periodCount;
	reg [15:0] supplyMv;

	wire        msTick;
	wire        guardMet;
	wire        cmdTaken;
	wire        leaveCmd;
	wire        writeOk;
	wire [16:0] cmdLimitMs;
	wire [15:0] sleepLimitMs;
	wire [27:0] supplyProd;
	wire [27:0] supplyQuot;
	reg  [15:0] next_readData;

	cms_ms_tick #(
		.DIV(MS_CYCLES)
	) u_tick (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.tick   (msTick)
	);

	// range check shared by the timeout, guard time, sleep interval and idle-before parameters
	function inRange;
		input [15:0] value;
		input [15:0] lo;
		input [15:0] hi;
		begin
			inRange = (value >= lo) && (value <= hi);
		end
	endfunction

	// sleep length rounded up to quarter seconds and capped at 28 s
	function [15:0] effectiveUnits;
		input [15:0] units;
		reg   [15:0] quarters;
		reg   [15:0] rounded;
		begin
			quarters = (units + `CMS_QUARTER_UNITS - 16'd1) / `CMS_QUARTER_UNITS;
			rounded  = quarters * `CMS_QUARTER_UNITS;
			effectiveUnits = (rounded > `CMS_MAX_SLEEP_UNITS) ? `CMS_MAX_SLEEP_UNITS : rounded;
		end
	endfunction

	// commands only reach the parameters as coded fields in command mode
	assign cmdTaken     = cmdValid && modeState == MODE_CMD;
	assign leaveCmd     = cmdTaken && cmdCode == `CMS_CMD_LEAVE_CMD_MODE;
	assign guardMet     = silentMs >= guard_time;
	assign cmdLimitMs   = {1'b0, command_mode_timeout} * `CMS_CMD_UNIT_MS;
	assign sleepLimitMs = effectiveUnits(sleep_interval) * `CMS_SLEEP_UNIT_MS;
	assign supplyProd   = {12'h000, supplyRaw} * `CMS_SUPPLY_MUL;
	// divide the full product; only the quotient is cut to the reply width
	assign supplyQuot   = supplyProd / `CMS_SUPPLY_DIV;

	// write legality per parameter; bad values are refused, not clipped
	function writeLegal;
		input [3:0]  code;
		input [15:0] data;
		begin
			case (code)
				`CMS_CMD_CMD_TIMEOUT:
					writeLegal = inRange(data, `CMS_MIN_CMD_TIMEOUT, `CMS_MAX_CMD_TIMEOUT);
				`CMS_CMD_GUARD_TIME:
					writeLegal = inRange(data, `CMS_MIN_GUARD_TIME, `CMS_MAX_GUARD_TIME);
				`CMS_CMD_ESCAPE_CHAR:
					writeLegal = data[15:8] == 8'h00;
				`CMS_CMD_SLEEP_MODE:
					writeLegal = data == {8'h00, `CMS_SLEEP_OFF} || data == {8'h00, `CMS_SLEEP_PIN} ||
						data == {8'h00, `CMS_SLEEP_CYCLIC};
				`CMS_CMD_SILENT_WAKE:
					writeLegal = data >= `CMS_MIN_SILENT_WAKE;
				`CMS_CMD_SLEEP_INTERVAL:
					writeLegal = inRange(data, `CMS_MIN_SLEEP_INTERVAL, `CMS_MAX_SLEEP_INTERVAL);
				`CMS_CMD_IDLE_BEFORE:
					writeLegal = inRange(data, `CMS_MIN_IDLE_BEFORE, `CMS_MAX_IDLE_BEFORE);
				default:
					writeLegal = 1'b0;
			endcase
		end
	endfunction

	assign writeOk = writeLegal(cmdCode, cmdData);

	// read mux for queries
	always @* begin
		case (cmdCode)
			`CMS_CMD_FIRMWARE_REV:   next_readData = FIRMWARE_REV;
			`CMS_CMD_HARDWARE_REV:   next_readData = HARDWARE_REV;
			`CMS_CMD_SUPPLY_VOLTAGE: next_readData = supplyMv;
			`CMS_CMD_CMD_TIMEOUT:    next_readData = command_mode_timeout;
			`CMS_CMD_GUARD_TIME:     next_readData = guard_time;
			`CMS_CMD_ESCAPE_CHAR:    next_readData = {8'h00, escape_character};
			`CMS_CMD_SLEEP_MODE:     next_readData = {8'h00, sleep_mode_select};
			`CMS_CMD_SILENT_WAKE:    next_readData = silent_wake_count;
			`CMS_CMD_SLEEP_INTERVAL: next_readData = sleep_interval;
			`CMS_CMD_IDLE_BEFORE:    next_readData = idle_before_sleep;
			default:                 next_readData = 16'h0000;
		endcase
	end

	// supply scaling, registered once per cycle from the raw sample
	always @(posedge ref_clk) begin
		if (!reset_n)
			supplyMv <= 16'h0000;
		else
			supplyMv <= supplyQuot[15:0];
	end

	// command port: parameter writes, queries and response strobe
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			command_mode_timeout <= `CMS_RST_CMD_TIMEOUT;
			guard_time           <= `CMS_RST_GUARD_TIME;
			escape_character     <= `CMS_RST_ESCAPE_CHAR;
			sleep_mode_select    <= `CMS_RST_SLEEP_MODE;
			silent_wake_count    <= `CMS_RST_SILENT_WAKE;
			sleep_interval       <= `CMS_RST_SLEEP_INTERVAL;
			idle_before_sleep    <= `CMS_RST_IDLE_BEFORE;
			rspValid             <= 1'b0;
			rspError             <= 1'b0;
			rspData              <= 16'h0000;
			rejoinPulse          <= 1'b0;
		end else begin
			rspValid    <= cmdTaken;
			rejoinPulse <= 1'b0;
			if (cmdTaken) begin
				rspError <= cmdWrite && !writeOk && !leaveCmd;
				rspData  <= cmdWrite ? 16'h0000 : next_readData;
				if (cmdWrite && writeOk) begin
					case (cmdCode)
						`CMS_CMD_CMD_TIMEOUT:    command_mode_timeout <= cmdData;
						`CMS_CMD_GUARD_TIME:     guard_time <= cmdData;
						`CMS_CMD_ESCAPE_CHAR:    escape_character <= cmdData[7:0];
						`CMS_CMD_SILENT_WAKE:    silent_wake_count <= cmdData;
						`CMS_CMD_SLEEP_INTERVAL: sleep_interval <= cmdData;
						`CMS_CMD_IDLE_BEFORE:    idle_before_sleep <= cmdData;
						`CMS_CMD_SLEEP_MODE: begin
							sleep_mode_select <= cmdData[7:0];
							// router leaves and rejoins as end device
							rejoinPulse <= sleep_mode_select == `CMS_SLEEP_OFF &&
								cmdData[7:0] != `CMS_SLEEP_OFF;
						end
						default: ;
					endcase
				end
			end
		end
	end

	// silence meter since the last serial byte, saturating
	always @(posedge ref_clk) begin
		if (!reset_n)
			silentMs <= 16'h0000;
		else if (rxValid)
			silentMs <= 16'h0000;
		else if (msTick && silentMs != 16'hffff)
			silentMs <= silentMs + 16'h0001;
	end

	// command mode entry, timeout and explicit exit
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			modeState   <= MODE_IDLE;
			escCount    <= 2'h0;
			cmdIdleMs   <= 17'h00000;
			commandMode <= 1'b0;
		end else begin
			case (modeState)
				MODE_IDLE: begin
					cmdIdleMs <= 17'h00000;
					if (rxValid) begin
						// first escape needs prior silence, any other byte restarts
						if (rxByte == escape_character && escCount != `CMS_ESCAPE_COUNT &&
							(escCount != 2'h0 || guardMet))
							escCount <= escCount + 2'h1;
						else
							escCount <= 2'h0;
					end else if (escCount == `CMS_ESCAPE_COUNT && guardMet) begin
						modeState   <= MODE_CMD;
						commandMode <= 1'b1;
						escCount    <= 2'h0;
					end
				end
				MODE_CMD: begin
					escCount <= 2'h0;
					if (leaveCmd) begin
						modeState   <= MODE_IDLE;
						commandMode <= 1'b0;
					end else if (cmdTaken) begin
						cmdIdleMs <= 17'h00000;
					end else if (cmdIdleMs >= cmdLimitMs) begin
						modeState   <= MODE_IDLE;
						commandMode <= 1'b0;
					end else if (msTick) begin
						cmdIdleMs <= cmdIdleMs + 17'h00001;
					end
				end
				default: begin
					modeState   <= MODE_IDLE;
					commandMode <= 1'b0;
				end
			endcase
		end
	end

	// sleep sequencing; a router (sleep off) never leaves the awake state
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			sleepState      <= SLP_AWAKE;
			idleMs          <= 16'h0000;
			sleepMs         <= 16'h0000;
			periodCount     <= 16'h0000;
			sleeping        <= 1'b0;
			awakeIndicator  <= 1'b1;
			routerRole      <= 1'b1;
			bufferHoldUnits <= `CMS_RST_SLEEP_INTERVAL;
		end else begin
			routerRole      <= sleep_mode_select == `CMS_SLEEP_OFF;
			bufferHoldUnits <= sleep_interval;
			case (sleepState)
				SLP_AWAKE: begin
					sleepMs <= 16'h0000;
					if (rxValid || radioRx)
						idleMs <= 16'h0000;
					else if (msTick && idleMs != 16'hffff)
						idleMs <= idleMs + 16'h0001;
					if (sleep_mode_select == `CMS_SLEEP_PIN && sleepPinRequest) begin
						sleepState     <= SLP_ASLEEP;
						sleeping       <= 1'b1;
						awakeIndicator <= 1'b0;
					end else if (sleep_mode_select == `CMS_SLEEP_CYCLIC && !rxValid && !radioRx &&
						idleMs >= idle_before_sleep && !commandMode) begin
						sleepState     <= SLP_ASLEEP;
						sleeping       <= 1'b1;
						awakeIndicator <= 1'b0;
					end
				end
				SLP_ASLEEP: begin
					idleMs <= 16'h0000;
					if (sleep_mode_select == `CMS_SLEEP_PIN) begin
						if (!sleepPinRequest) begin
							sleepState     <= SLP_AWAKE;
							sleeping       <= 1'b0;
							awakeIndicator <= 1'b1;
						end
					end else if (sleep_mode_select != `CMS_SLEEP_CYCLIC) begin
						// mode changed while asleep: wake and stay awake
						sleepState     <= SLP_AWAKE;
						sleeping       <= 1'b0;
						awakeIndicator <= 1'b1;
					end else if (sleepMs >= sleepLimitMs) begin
						sleepMs <= 16'h0000;
						// period over: pending radio data or enough silent periods wake the host
						if (radioPending || periodCount + 16'h0001 >= silent_wake_count) begin
							sleepState     <= SLP_AWAKE;
							sleeping       <= 1'b0;
							awakeIndicator <= 1'b1;
							periodCount    <= 16'h0000;
						end else begin
							periodCount <= periodCount + 16'h0001;
						end
					end else if (msTick) begin
						sleepMs <= sleepMs + 16'h0001;
					end
				end
				default: begin
					sleepState     <= SLP_AWAKE;
					sleeping       <= 1'b0;
					awakeIndicator <= 1'b1;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

/* tb/cms_control_chk.sv */
/* Port checker of cms_control.
   Assumes one ref_clk domain; bound at the foot. */
`default_nettype none
module cms_control_chk (
	input wire logic        ref_clk,
	input wire logic        reset_n,
	input wire logic        rxValid,
	input wire logic        cmdValid,
	input wire logic        cmdWrite,
	input wire logic [3:0]  cmdCode,
	input wire logic [15:0] cmdData,
	input wire logic        rspValid,
	input wire logic        rspError,
	input wire logic        commandMode,
	input wire logic        routerRole,
	input wire logic        rejoinPulse,
	input wire logic        sleeping,
	input wire logic        awakeIndicator
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// a taken command, then a write to one selector
	sequence sTaken;
		cmdValid && commandMode;
	endsequence
	sequence sWr(c);
		sTaken ##0 (cmdWrite && cmdCode == c);
	endsequence
	a_cmd_answer: assert property (sTaken |=> rspValid) else $error("no answer");
	a_idle_quiet: assert property (!(cmdValid && commandMode) |=> !rspValid) else $error("stray answer");
	a_leave_exit: assert property (sTaken ##0 cmdCode == 4'hf |=> !commandMode && !rspError)
		else $error("leave failed");
	a_ro_refused: assert property (sTaken ##0 (cmdWrite && cmdCode <= 4'h2) |=> rspError)
		else $error("read-only write taken");
	a_escape_wide: assert property (sWr(4'h5) ##0 cmdData[15:8] != 8'h00 |=> rspError)
		else $error("wide escape taken");
	a_mode_legal: assert property (sWr(4'h6) ##0 !(cmdData inside {16'h0, 16'h1, 16'h4}) |=> rspError)
		else $error("bad mode taken");
	a_rejoin_cause: assert property (sWr(4'h6) ##0 (cmdData inside {16'h1, 16'h4} && routerRole) |=> ##[0:1] rejoinPulse)
		else $error("no rejoin");
	a_router_wake: assert property (routerRole |-> !sleeping) else $error("router asleep");
	a_sleep_dark: assert property (sleeping |-> !awakeIndicator) else $error("awake while asleep");
	a_entry_quiet: assert property (rxValid |=> (!$rose(commandMode)) [*3])
		else $error("entry without silence");
endmodule

bind cms_control cms_control_chk chk (.ref_clk(ref_clk), .reset_n(reset_n), .rxValid(rxValid),
	.cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData), .rspValid(rspValid),
	.rspError(rspError), .commandMode(commandMode), .routerRole(routerRole), .rejoinPulse(rejoinPulse),
	.sleeping(sleeping), .awakeIndicator(awakeIndicator));
`default_nettype wire

/* tb/cms_host_model.sv */
/* Host on the serial side: sends bytes as one-cycle strobes.
   Assumes ref_clk of the block; driven at falling edges. */
`default_nettype none
module cms_host_model (
	input  wire logic       ref_clk,
	output var  logic       rxValid,
	output var  logic [7:0] rxByte
);
	timeunit 1ns;
	timeprecision 1ns;
	// line idle at start
	initial begin
		rxValid = 1'b0;
		rxByte  = 8'h00;
	end
	// one byte; stale value inverted so it never looks valid
	task automatic send_byte(input logic [7:0] b);
		@(negedge ref_clk);
		rxValid = 1'b1;
		rxByte  = b;
		@(negedge ref_clk);
		rxValid = 1'b0;
		rxByte  = ~b;
	endtask
	// leading silence then three escapes; caller waits the trailing guard
	task automatic escape(input logic [7:0] c, input int quiet);
		repeat (quiet) @(negedge ref_clk);
		repeat (3) send_byte(c);
	endtask
endmodule
`default_nettype wire

/* tb/cms_control_tb.sv */
/* Self-checking bench of cms_control: command tasks, escape entry,
   timeout and sleep. Assumes the checker binds itself; 1 ms = 10 cycles. */
`default_nettype none
module cms_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        rxValid;
	logic [7:0]  rxByte;
	logic        radioRx = 1'b0;
	logic        radioPending = 1'b0;
	logic        sleepPinRequest = 1'b0;
	logic [15:0] supplyRaw = 16'd50;
	logic        cmdValid = 1'b0;
	logic        cmdWrite = 1'b0;
	logic [3:0]  cmdCode = 4'h0;
	logic [15:0] cmdData = 16'h0;
	logic        rspValid, rspError, commandMode, routerRole, rejoinPulse, sleeping, awakeIndicator;
	logic [15:0] rspData, bufferHoldUnits, q;
	logic        e;
	int          err_total = 0;
	int          checks_done = 0;
	logic [15:0] cur [0:9];
	logic [23:0] wr [$];

	cms_host_model host (.ref_clk(ref_clk), .rxValid(rxValid), .rxByte(rxByte));
	cms_control #(.MS_CYCLES(10)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .rxValid(rxValid),
		.rxByte(rxByte), .radioRx(radioRx), .radioPending(radioPending), .sleepPinRequest(sleepPinRequest),
		.supplyRaw(supplyRaw), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData),
		.rspValid(rspValid), .rspError(rspError), .rspData(rspData), .commandMode(commandMode),
		.routerRole(routerRole), .rejoinPulse(rejoinPulse), .sleeping(sleeping),
		.awakeIndicator(awakeIndicator), .bufferHoldUnits(bufferHoldUnits));

	// 250 MHz
	always #2 ref_clk = ~ref_clk;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// strobe left high so calls run back to back
	task automatic cmd(input logic w, input logic [3:0] c, input logic [15:0] d);
		cmdValid = 1'b1;
		cmdWrite = w;
		cmdCode  = c;
		cmdData  = d;
		@(negedge ref_clk);
		chk({15'h0, rspValid}, 16'h1);
		q = rspData;
		e = rspError;
	endtask
	task automatic idle;
		cmdValid = 1'b0;
		@(negedge ref_clk);
	endtask
	// bounded wait on command mode (s=0) or sleeping (s=1)
	task automatic waitf(input bit s, input logic v, input int lim);
		while (lim > 0 && (s ? sleeping : commandMode) !== v) begin
			lim--;
			@(negedge ref_clk);
		end
		chk({15'h0, s ? sleeping : commandMode}, {15'h0, v});
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// scenarios in order; each leans on the state the previous left
	initial begin
		cur = '{16'h1234, 16'h0abc, 16'h003a, 16'h0064, 16'h03e8, 16'h002b, 16'h0000, 16'h0001, 16'h0020, 16'h1388};
		wr = '{24'h100000, 24'h110000, 24'h120000, 24'h130001, 24'h130290, 24'h03028f, 24'h030002, 24'h140000,
			24'h140ce5, 24'h040ce4, 24'h040002, 24'h150141, 24'h050041, 24'h160002, 24'h170000, 24'h070002,
			24'h18001f, 24'h180af1, 24'h080040, 24'h190000, 24'h19ffff, 24'h090005, 24'h1e0000};
		repeat (8) @(negedge ref_clk);
		reset_n = 1'b1;
		chk({10'h0, commandMode, routerRole, sleeping, awakeIndicator, rspValid, rejoinPulse}, 16'h0014);
		chk(bufferHoldUnits, 16'h0020);
		host.escape(8'h2b, 10020);
		waitf(0, 1'b1, 10100);
		for (int i = 0; i < 10; i++) begin
			cmd(1'b0, i[3:0], 16'h0);
			chk(q, cur[i]);
		end
		// writes back to back, each refused or read back
		foreach (wr[i]) begin
			cmd(1'b1, wr[i][19:16], wr[i][15:0]);
			chk({15'h0, e}, {15'h0, wr[i][20]});
			if (!wr[i][20])
				cur[wr[i][19:16]] = wr[i][15:0];
			if (wr[i][19:16] < 4'ha) begin
				cmd(1'b0, wr[i][19:16], 16'h0);
				chk(q, cur[wr[i][19:16]]);
			end
		end
		cmd(1'b1, 4'h6, 16'h0001);
		chk({15'h0, e}, 16'h0);
		chk({15'h0, rejoinPulse}, 16'h1);
		idle();
		chk({15'h0, routerRole}, 16'h0);
		chk(bufferHoldUnits, 16'h0040);
		cmd(1'b0, 4'hf, 16'h0);
		chk({14'h0, e, commandMode}, 16'h0);
		idle();
		sleepPinRequest = 1'b1;
		repeat (3) @(negedge ref_clk);
		chk({15'h0, sleeping}, 16'h1);
		sleepPinRequest = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk({15'h0, sleeping}, 16'h0);
		host.escape(8'h2b, 40);
		repeat (40) @(negedge ref_clk);
		chk({15'h0, commandMode}, 16'h0);
		host.escape(8'h41, 40);
		waitf(0, 1'b1, 60);
		cmd(1'b1, 4'h6, 16'h0004);
		chk({15'h0, e}, 16'h0);
		idle();
		repeat (1900) @(negedge ref_clk);
		chk({15'h0, commandMode}, 16'h1);
		waitf(0, 1'b0, 300);
		waitf(1, 1'b1, 80);
		repeat (7700) @(negedge ref_clk);
		chk({15'h0, sleeping, awakeIndicator}, 16'h2);
		waitf(1, 1'b0, 7500);
		chk({15'h0, awakeIndicator}, 16'h1);
		// radio traffic every 3 ms holds off the 5 ms idle timer
		repeat (6) begin
			radioRx = 1'b1;
			@(negedge ref_clk);
			radioRx = 1'b0;
			repeat (29) @(negedge ref_clk);
		end
		chk({15'h0, sleeping}, 16'h0);
		waitf(1, 1'b1, 80);
		radioPending = 1'b1;
		waitf(1, 1'b0, 7600);
		test_done();
	end

	// watchdog well beyond the 45k cycles the run needs
	initial begin
		#300us;
		err_total++;
		test_done();
	end
endmodule
`default_nettype wire
